// File: agct_pkg.sv
// constants, field layout and fsm states of the right gain timing,
// adc filter path and control bus check register bank
// assumes one 10 MHz core clock and an 8-bit register space
package agct_pkg;

    // ****************************************
    // register offsets, reset value and path write mask
    // ****************************************
    localparam logic [7:0] AGCT_ATK_ADDR = 8'h69;
    localparam logic [7:0] AGCT_DCY_ADDR = 8'h6A;
    localparam logic [7:0] AGCT_PATH_ADDR = 8'h6B;
    localparam logic [7:0] AGCT_RST_VAL = 8'h00;
    localparam logic [7:0] AGCT_PATH_WMASK = 8'hFC;

    // ****************************************
    // field positions
    // ****************************************
    localparam int AGCT_SRC_BIT = 7;
    localparam int AGCT_BASE_HI = 6;
    localparam int AGCT_BASE_LO = 5;
    localparam int AGCT_MULT_HI = 4;
    localparam int AGCT_MULT_LO = 2;
    localparam int AGCT_HPF_L_BIT = 7;
    localparam int AGCT_HPF_R_BIT = 6;
    localparam int AGCT_FPATH_BIT = 3;
    localparam int AGCT_DET_DIS_BIT = 2;
    localparam int AGCT_ERR_BIT = 0;

    // ****************************************
    // times in milliseconds, minimum widths and byte length
    // ****************************************
    localparam logic [15:0] AGCT_ATK_MS0 = 16'h0007;
    localparam logic [15:0] AGCT_ATK_MS1 = 16'h0008;
    localparam logic [15:0] AGCT_ATK_MS2 = 16'h000A;
    localparam logic [15:0] AGCT_ATK_MS3 = 16'h000B;
    localparam logic [15:0] AGCT_DCY_MS0 = 16'h0032;
    localparam logic [15:0] AGCT_DCY_MS1 = 16'h0096;
    localparam logic [15:0] AGCT_DCY_MS2 = 16'h00FA;
    localparam logic [15:0] AGCT_DCY_MS3 = 16'h015E;
    // decay caps: 4, 5.6, 8, 9.6, 11.2, 16, 19.2, 22.4 s
    localparam logic [15:0] AGCT_CAP_4000 = 16'h0FA0;
    localparam logic [15:0] AGCT_CAP_5600 = 16'h15E0;
    localparam logic [15:0] AGCT_CAP_8000 = 16'h1F40;
    localparam logic [15:0] AGCT_CAP_9600 = 16'h2580;
    localparam logic [15:0] AGCT_CAP_11200 = 16'h2BC0;
    localparam logic [15:0] AGCT_CAP_16000 = 16'h3E80;
    localparam logic [15:0] AGCT_CAP_19200 = 16'h4B00;
    localparam logic [15:0] AGCT_CAP_22400 = 16'h5780;
    localparam int AGCT_ATK_MIN_W = 11;
    localparam int AGCT_DCY_MIN_W = 16;
    localparam logic [3:0] AGCT_BYTE_BITS = 4'h8;

    // ****************************************
    // serial slave states
    // ****************************************
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_ADDR = 8'h02,
        ST_ACK_ADDR = 8'h04,
        ST_REG = 8'h08,
        ST_ACK_REG = 8'h10,
        ST_WDATA = 8'h20,
        ST_RDATA = 8'h40,
        ST_RACK = 8'h80
    } agct_state_type;

endpackage : agct_pkg

// File: agct_regs.sv
// right gain timing, adc filter path and bus check registers,
// reached through a two-wire serial slave
// assumes scl/sda arrive asynchronously, open-drain sda resolved outside
`timescale 1ns/100ps
module agct_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary value
    parameter int ATK_W = 11,
    parameter int DCY_W = 16
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // two-wire control bus
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // legacy timing and codec state
    input wire logic [ATK_W-1:0] legacy_attack_ms_i,
    input wire logic [DCY_W-1:0] legacy_decay_ms_i,
    input wire logic [3:0] adc_rate_divider_ratio_i,
    input wire logic adc_hpf_en_i,
    input wire logic left_dac_pd_i,
    input wire logic right_dac_pd_i,
    // applied settings
    output logic [ATK_W-1:0] attack_ms_o,
    output logic [DCY_W-1:0] decay_ms_o,
    output logic hpf_left_prog_o,
    output logic hpf_right_prog_o,
    output logic prog_filter_on_adc_o,
    output logic bus_err_o
);
    import agct_pkg::*;

    // ****************************************
    // elaboration checks
    // ****************************************
    if (ATK_W < AGCT_ATK_MIN_W || DCY_W < AGCT_DCY_MIN_W) begin : g_chk
        $error("attack or decay width too narrow");
    end

    // ****************************************
    // decoding functions
    // ****************************************
    function automatic logic [15:0] atk_base(input logic [1:0] c);
        unique case (c)
            2'h0: atk_base = AGCT_ATK_MS0;
            2'h1: atk_base = AGCT_ATK_MS1;
            2'h2: atk_base = AGCT_ATK_MS2;
            default: atk_base = AGCT_ATK_MS3;
        endcase
    endfunction : atk_base

    function automatic logic [15:0] dcy_base(input logic [1:0] c);
        unique case (c)
            2'h0: dcy_base = AGCT_DCY_MS0;
            2'h1: dcy_base = AGCT_DCY_MS1;
            2'h2: dcy_base = AGCT_DCY_MS2;
            default: dcy_base = AGCT_DCY_MS3;
        endcase
    endfunction : dcy_base

    // ratio coded in half steps: 0 is 1.0, 10 is 6.0
    function automatic logic [15:0] dcy_cap(input logic [3:0] r);
        case (r)
            4'h0: dcy_cap = AGCT_CAP_4000;
            4'h1: dcy_cap = AGCT_CAP_5600;
            4'h2: dcy_cap = AGCT_CAP_8000;
            4'h3: dcy_cap = AGCT_CAP_9600;
            4'h4, 4'h5: dcy_cap = AGCT_CAP_11200;
            4'h6, 4'h7: dcy_cap = AGCT_CAP_16000;
            4'h8: dcy_cap = AGCT_CAP_19200;
            default: dcy_cap = AGCT_CAP_22400;
        endcase
    endfunction : dcy_cap

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [2:0] scl_sync_r;
    logic [2:0] sda_sync_r;
    logic scl_f_r;
    logic sda_f_r;
    logic scl_p_r;
    logic sda_p_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scl_sync_r <= 3'h7;
            sda_sync_r <= 3'h7;
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
            scl_p_r <= 1'b1;
            sda_p_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[1:0], scl_i};
            sda_sync_r <= {sda_sync_r[1:0], sda_i};
            // first stage feeds only the second
            if (scl_sync_r[1] == scl_sync_r[2]) begin
                scl_f_r <= scl_sync_r[2];
            end
            if (sda_sync_r[1] == sda_sync_r[2]) begin
                sda_f_r <= sda_sync_r[2];
            end
            scl_p_r <= scl_f_r;
            sda_p_r <= sda_f_r;
        end
    end

    // ****************************************
    // bus events
    // ****************************************
    agct_state_type st_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic [7:0] ptr_r;
    logic rw_r;
    logic oe_r;
    logic [7:0] atk_r;
    logic [7:0] dcy_r;
    logic [7:0] path_r;
    logic err_r;

    wire scl_rise = scl_f_r & ~scl_p_r;
    wire scl_fall = ~scl_f_r & scl_p_r;
    wire start_ev = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
    wire stop_ev = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;
    wire det_en = ~path_r[AGCT_DET_DIS_BIT];
    // the scl rise ahead of a stop or repeated start counts one bit,
    // so only a start or stop later in a byte or its ack is an error
    wire in_byte = (st_r != ST_IDLE) && (bit_r > 4'h1);
    wire err_set = det_en & (start_ev | stop_ev) & in_byte;
    wire quiet = ~err_set & ~start_ev & ~stop_ev;
    wire byte_done = bit_r == AGCT_BYTE_BITS;
    wire wr_en = quiet & scl_fall & (st_r == ST_WDATA) & byte_done;
    wire rd_load = quiet & scl_fall
        & (((st_r == ST_ACK_ADDR) & rw_r) | (st_r == ST_RACK));
    wire rd_clr = rd_load & (ptr_r == AGCT_PATH_ADDR);
    wire [7:0] path_rd = {path_r[7:2], 1'b0, err_r};
    wire [7:0] rd_data = (ptr_r == AGCT_ATK_ADDR) ? atk_r
        : (ptr_r == AGCT_DCY_ADDR) ? dcy_r
        : (ptr_r == AGCT_PATH_ADDR) ? path_rd : AGCT_RST_VAL;

    // ****************************************
    // serial slave
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            oe_r <= 1'b0;
        end else if (err_set) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (start_ev) begin
            st_r <= ST_ADDR;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (stop_ev) begin
            st_r <= ST_IDLE;
            bit_r <= 4'h0;
            oe_r <= 1'b0;
        end else if (scl_rise) begin
            unique case (st_r)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    sh_r <= {sh_r[6:0], sda_f_r};
                    bit_r <= bit_r + 4'h1;
                end
                ST_RDATA: bit_r <= bit_r + 4'h1;
                // nack from master ends the read
                ST_RACK: if (sda_f_r) st_r <= ST_IDLE;
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (st_r)
                ST_ADDR: if (byte_done) begin
                    if (sh_r[7:1] == DEV_ADDR) begin
                        st_r <= ST_ACK_ADDR;
                        rw_r <= sh_r[0];
                        oe_r <= 1'b1;
                    end else begin
                        st_r <= ST_IDLE;
                    end
                end
                ST_REG: if (byte_done) begin
                    ptr_r <= sh_r;
                    st_r <= ST_ACK_REG;
                    oe_r <= 1'b1;
                end
                ST_WDATA: if (byte_done) begin
                    ptr_r <= ptr_r + 8'h01;
                    st_r <= ST_ACK_REG;
                    oe_r <= 1'b1;
                end
                ST_ACK_ADDR, ST_RACK: if (rd_load) begin
                    sh_r <= rd_data;
                    oe_r <= ~rd_data[7];
                    bit_r <= 4'h0;
                    ptr_r <= ptr_r + 8'h01;
                    st_r <= ST_RDATA;
                end else begin
                    oe_r <= 1'b0;
                    bit_r <= 4'h0;
                    st_r <= ST_REG;
                end
                ST_ACK_REG: begin
                    oe_r <= 1'b0;
                    bit_r <= 4'h0;
                    st_r <= ST_WDATA;
                end
                ST_RDATA: if (byte_done) begin
                    oe_r <= 1'b0;
                    st_r <= ST_RACK;
                end else begin
                    sh_r <= {sh_r[6:0], 1'b0};
                    oe_r <= ~sh_r[6];
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // ****************************************
    // register file
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            atk_r <= AGCT_RST_VAL;
            dcy_r <= AGCT_RST_VAL;
            path_r <= AGCT_RST_VAL;
        end else if (wr_en) begin
            // low timing bits stored as written; host keeps them zero
            if (ptr_r == AGCT_ATK_ADDR) atk_r <= sh_r;
            if (ptr_r == AGCT_DCY_ADDR) dcy_r <= sh_r;
            if (ptr_r == AGCT_PATH_ADDR) begin
                path_r <= sh_r & AGCT_PATH_WMASK;
            end
        end
    end

    // set wins over the read clear so no error is lost
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) err_r <= 1'b0;
        else if (err_set) err_r <= 1'b1;
        else if (rd_clr) err_r <= 1'b0;
    end

    // ****************************************
    // applied timing and filter routing
    // ****************************************
    wire [2:0] atk_mult = atk_r[AGCT_MULT_HI:AGCT_MULT_LO];
    wire [2:0] dcy_mult = dcy_r[AGCT_MULT_HI:AGCT_MULT_LO];
    wire [ATK_W-1:0] atk_prog =
        ATK_W'(atk_base(atk_r[AGCT_BASE_HI:AGCT_BASE_LO])) << atk_mult;
    wire [DCY_W-1:0] dcy_prog =
        DCY_W'(dcy_base(dcy_r[AGCT_BASE_HI:AGCT_BASE_LO])) << dcy_mult;
    wire [ATK_W-1:0] atk_nxt = atk_r[AGCT_SRC_BIT] ? atk_prog
        : legacy_attack_ms_i;
    wire [DCY_W-1:0] dcy_sel = dcy_r[AGCT_SRC_BIT] ? dcy_prog
        : legacy_decay_ms_i;
    wire [DCY_W-1:0] cap_ms = DCY_W'(dcy_cap(adc_rate_divider_ratio_i));
    wire [DCY_W-1:0] dcy_nxt = (dcy_sel > cap_ms) ? cap_ms
        : dcy_sel;
    wire dacs_down = left_dac_pd_i & right_dac_pd_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            attack_ms_o <= '0;
            decay_ms_o <= '0;
            hpf_left_prog_o <= 1'b0;
            hpf_right_prog_o <= 1'b0;
            prog_filter_on_adc_o <= 1'b0;
        end else begin
            attack_ms_o <= atk_nxt;
            decay_ms_o <= dcy_nxt;
            hpf_left_prog_o <= adc_hpf_en_i & path_r[AGCT_HPF_L_BIT];
            hpf_right_prog_o <= adc_hpf_en_i & path_r[AGCT_HPF_R_BIT];
            // path held off while either dac runs
            prog_filter_on_adc_o <= path_r[AGCT_FPATH_BIT] & dacs_down;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_r;
    assign bus_err_o = err_r;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_rd_clear;
        rd_clr && !err_set;
    endsequence
    sequence seq_err_hit;
        err_set;
    endsequence

    AST_ATK_LEGACY: assert property (
        !atk_r[AGCT_SRC_BIT] |=> attack_ms_o == $past(legacy_attack_ms_i))
        else $error("attack not from legacy source");
    AST_ATK_PROG: assert property (
        atk_r[AGCT_SRC_BIT] |=> attack_ms_o == ($past(ATK_W'(atk_base(
            atk_r[AGCT_BASE_HI:AGCT_BASE_LO]))) << $past(atk_mult)))
        else $error("attack time not base times factor");
    AST_DCY_LEGACY: assert property (
        !dcy_r[AGCT_SRC_BIT] && legacy_decay_ms_i <= cap_ms
        |=> decay_ms_o == $past(legacy_decay_ms_i))
        else $error("decay not from legacy source");
    AST_DCY_CAP: assert property (
        ##1 decay_ms_o <= $past(cap_ms))
        else $error("decay time above cap");
    AST_HPF_SEL: assert property (
        hpf_left_prog_o |-> $past(adc_hpf_en_i)
        && $past(path_r[AGCT_HPF_L_BIT]))
        else $error("left hpf select without cause");
    AST_FPATH: assert property (
        prog_filter_on_adc_o |-> $past(dacs_down))
        else $error("filter on adc while a dac runs");
    AST_DET_OFF: assert property (
        path_r[AGCT_DET_DIS_BIT] && !err_r |=> !bus_err_o)
        else $error("error flagged with detector off");
    AST_ERR_SET: assert property (
        seq_err_hit |=> err_r && bus_err_o)
        else $error("bus error not reported");
    AST_RD_CLR: assert property (
        seq_rd_clear |=> !bus_err_o)
        else $error("status not cleared by read");
    AST_ERR_IDLE: assert property (
        seq_err_hit |=> st_r == ST_IDLE && !sda_oe_o
        ##1 (st_r == ST_IDLE || st_r == ST_ADDR))
        else $error("slave not idle after bus error");

endmodule : agct_regs

// File: agct_host.sv
// host controller model for the two-wire control bus
// assumes the bench resolves sda from all pull-downs with a pull-up
`timescale 1ns/100ps
module agct_host #(
    parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary value
) (
    // clock and bus
    input wire logic ref_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    import agct_pkg::*;
    // scl phase length; the bench raises it for a slow host
    int half = 16;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick
    // sda moves mid low phase, never next to an scl edge
    task automatic bit_tx(input logic b);
        tick(half / 2);
        sda_low_o = ~b;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        scl_o = 1'b0;
    endtask : bit_tx
    task automatic bit_rx(output logic b);
        tick(half / 2);
        sda_low_o = 1'b0;
        tick(half);
        scl_o = 1'b1;
        tick(half / 2);
        b = sda_i;
        tick(half / 2);
        scl_o = 1'b0;
    endtask : bit_rx
    // start when st is 1, stop otherwise
    task automatic cond(input logic st);
        tick(half / 2);
        sda_low_o = ~st;
        tick(half);
        scl_o = 1'b1;
        tick(half);
        sda_low_o = st;
        tick(half);
        scl_o = ~st;
    endtask : cond
    task automatic byte_tx(input logic [7:0] d, output logic ack);
        logic nak;
        for (int i = 7; i >= 0; i--) bit_tx(d[i]);
        bit_rx(nak);
        ack = ~nak;
    endtask : byte_tx
    task automatic write_reg(input logic [7:0] off, input logic [7:0] data,
                             output logic ack);
        logic [7:0] d;
        logic a0, a1, a2;
        d = data;
        if (off == AGCT_PATH_ADDR) d[5:4] = 2'b00;
        else d[1:0] = 2'b00;
        cond(1'b1);
        byte_tx({DEV_ADDR, 1'b0}, a0);
        byte_tx(off, a1);
        byte_tx(d, a2);
        cond(1'b0);
        ack = a0 & a1 & a2;
    endtask : write_reg
    task automatic read_reg(input logic [7:0] off, output logic [7:0] d,
                            output logic ack);
        logic a0, a1, a2;
        cond(1'b1);
        byte_tx({DEV_ADDR, 1'b0}, a0);
        byte_tx(off, a1);
        cond(1'b1);
        byte_tx({DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) bit_rx(d[i]);
        bit_tx(1'b1);
        cond(1'b0);
        ack = a0 & a1 & a2;
    endtask : read_reg
    // stop in mid byte, a deliberate bus error
    task automatic abort(input int n);
        cond(1'b1);
        repeat (n) bit_tx(1'b1);
        cond(1'b0);
    endtask : abort
endmodule : agct_host

// File: agct_regs_tb_top.sv
// self-checking bench of the right gain timing and path registers
// assumes agct_pkg, agct_regs and agct_host are compiled first
`timescale 1ns/100ps
module agct_regs_tb_top;
    import agct_pkg::*;
    logic ref_clk_i, rst_i, scl, sda, host_low, sda_o, sda_oe_o;
    logic [10:0] leg_atk, atk;
    logic [15:0] leg_dcy, dcy;
    logic [3:0] ratio;
    logic hpf_en, l_pd, r_pd, l_prog, r_prog, on_adc, bus_err;
    logic [7:0] d;
    logic a;
    int fail_count = 0;
    int cmp_count = 0;
    logic [15:0] atk_ms [0:3] = '{AGCT_ATK_MS0, AGCT_ATK_MS1,
        AGCT_ATK_MS2, AGCT_ATK_MS3};
    logic [15:0] dcy_ms [0:3] = '{AGCT_DCY_MS0, AGCT_DCY_MS1,
        AGCT_DCY_MS2, AGCT_DCY_MS3};
    logic [15:0] caps [0:11] = '{AGCT_CAP_4000, AGCT_CAP_5600,
        AGCT_CAP_8000, AGCT_CAP_9600, AGCT_CAP_11200, AGCT_CAP_11200,
        AGCT_CAP_16000, AGCT_CAP_16000, AGCT_CAP_19200, AGCT_CAP_22400,
        AGCT_CAP_22400, AGCT_CAP_22400};
    // open-drain wire with pull-up
    assign sda = ~(host_low | (sda_oe_o & ~sda_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    agct_regs uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .legacy_attack_ms_i(leg_atk), .legacy_decay_ms_i(leg_dcy),
        .adc_rate_divider_ratio_i(ratio), .adc_hpf_en_i(hpf_en),
        .left_dac_pd_i(l_pd), .right_dac_pd_i(r_pd), .attack_ms_o(atk),
        .decay_ms_o(dcy), .hpf_left_prog_o(l_prog),
        .hpf_right_prog_o(r_prog), .prog_filter_on_adc_o(on_adc),
        .bus_err_o(bus_err));
    agct_host host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
        .sda_low_o(host_low));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic settle();
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask : settle
    task automatic wr(input logic [7:0] off, input logic [7:0] v);
        logic ak;
        host.write_reg(off, v, ak);
        check("write ack", 16'(ak), 16'h1);
        settle();
    endtask : wr
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        check("atk legacy", 16'(atk), 16'(leg_atk));
        check("dcy legacy", dcy, leg_dcy);
        for (int r = 0; r < 3; r++) begin
            host.read_reg(AGCT_ATK_ADDR + 8'(r), d, a);
            check("read ack", 16'(a), 16'h1);
            check("reset value", 16'(d), 16'(AGCT_RST_VAL));
        end
    endtask : t_reset
    // each step covers one multiplier code and cycles the bases
    task automatic t_attack();
        for (int i = 0; i < 8; i++) begin
            wr(AGCT_ATK_ADDR, {1'b1, 2'(i % 4), 3'(i), 2'b00});
            check("attack", 16'(atk), atk_ms[i % 4] << i);
        end
        host.read_reg(AGCT_ATK_ADDR, d, a);
        check("atk readback", 16'(d), 16'h00FC);
        wr(AGCT_ATK_ADDR, 8'h7C);
        check("atk source", 16'(atk), 16'(leg_atk));
    endtask : t_attack
    task automatic t_decay();
        logic [15:0] raw;
        ratio = 4'hA;
        for (int i = 0; i < 8; i++) begin
            wr(AGCT_DCY_ADDR, {1'b1, 2'(i % 4), 3'(i), 2'b00});
            raw = dcy_ms[i % 4] << i;
            check("decay", dcy, raw > caps[10] ? caps[10] : raw);
        end
        for (int r = 0; r < 12; r++) begin
            ratio = 4'(r);
            settle();
            check("decay cap", dcy, caps[r]);
        end
        wr(AGCT_DCY_ADDR, 8'h7C);
        check("dcy source", dcy, leg_dcy);
    endtask : t_decay
    task automatic t_path();
        hpf_en = 1'b1;
        l_pd = 1'b1;
        r_pd = 1'b1;
        wr(AGCT_PATH_ADDR, 8'hCB);
        check("hpf left", 16'(l_prog), 16'h1);
        check("hpf right", 16'(r_prog), 16'h1);
        check("filter on", 16'(on_adc), 16'h1);
        r_pd = 1'b0;
        settle();
        check("filter dac up", 16'(on_adc), 16'h0);
        host.read_reg(AGCT_PATH_ADDR, d, a);
        check("path readback", 16'(d), 16'h00C8);
        r_pd = 1'b1;
        wr(AGCT_PATH_ADDR, 8'h40);
        check("hpf left off", 16'(l_prog), 16'h0);
        check("hpf right on", 16'(r_prog), 16'h1);
        check("filter off", 16'(on_adc), 16'h0);
        hpf_en = 1'b0;
        settle();
        check("hpf right no hpf", 16'(r_prog), 16'h0);
    endtask : t_path
    // slow host during the error; detector on, then off
    task automatic t_err();
        wr(AGCT_PATH_ADDR, 8'h00);
        check("no err on stop", 16'(bus_err), 16'h0);
        host.half = 24;
        host.abort(3);
        settle();
        check("err set", 16'(bus_err), 16'h1);
        host.read_reg(AGCT_PATH_ADDR, d, a);
        check("ack after err", 16'(a), 16'h1);
        check("err read", 16'(d), 16'h0001);
        check("err cleared", 16'(bus_err), 16'h0);
        host.half = 16;
        wr(AGCT_PATH_ADDR, 8'h04);
        host.abort(5);
        settle();
        check("err off", 16'(bus_err), 16'h0);
    endtask : t_err
    initial begin
        rst_i = 1'b1;
        leg_atk = 11'h123;
        leg_dcy = 16'h0BB8;
        ratio = 4'h0;
        hpf_en = 1'b0;
        l_pd = 1'b0;
        r_pd = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        settle();
        t_reset();
        t_attack();
        t_decay();
        t_path();
        t_err();
        results();
    end
    // hang guard, about twice the expected run
    initial begin
        repeat (70000) @(posedge ref_clk_i);
        fail_count++;
        results();
    end
endmodule : agct_regs_tb_top
